/* File: pbm_pkg.sv */
// Package of constants and register map for the port B alternate function mux.
package pbm_pkg;
    // ==========================================================
    // Register byte addresses (APB, one aligned word each)
    localparam logic [7:0] PBM_CTRL_OFS   = 8'h00;
    localparam logic [7:0] PBM_FUSE_OFS   = 8'h04;
    localparam logic [7:0] PBM_SRC_OFS    = 8'h08;
    localparam logic [7:0] PBM_STAT_OFS   = 8'h0C;
    localparam logic [7:0] PBM_OVR_OFS    = 8'h10;
    // ==========================================================
    // Field positions of the control register
    localparam int PBM_CTRL_PORT_LSB  = 0;
    localparam int PBM_CTRL_DIR_LSB   = 4;
    localparam int PBM_CTRL_MASK_LSB  = 8;
    localparam int PBM_CTRL_GRP_BIT   = 12;
    localparam int PBM_CTRL_EXT_IRQ_ZERO_BIT  = 13;
    // Field positions of the fuse register; a fuse bit of 0 means programmed.
    localparam int PBM_FUSE_SYSCLK_OUT_FUSE_BIT = 0;
    localparam int PBM_FUSE_RSTD_BIT  = 1;
    localparam int PBM_FUSE_ONEWIRE_DEBUG_FUSE_BIT  = 2;
    localparam int PBM_FUSE_LOCK_LSB  = 4;
    localparam int PBM_LOCK_W         = 2;
    // Clock source codes in the source register.
    localparam logic [1:0] PBM_CLK_RC     = 2'h0;
    localparam logic [1:0] PBM_CLK_EXT    = 2'h1;
    localparam logic [1:0] PBM_CLK_XTAL   = 2'h2;
    localparam logic [1:0] PBM_CLK_LFXTAL = 2'h3;
    // ==========================================================
    // Reset values; fuses come up unprogrammed.
    localparam logic [31:0] PBM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PBM_FUSE_RST = 32'h0000_0037;
    localparam logic [31:0] PBM_SRC_RST  = 32'h0000_0000;
    localparam int PBM_NPIN = 4;
endpackage

/* File: pbm_pin_mux.sv */
// One pin's override combiner, registered.
`timescale 1ns/1ps
`default_nettype none
module pbm_pin_mux
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic reg_pullup,
    input  wire logic reg_dir,
    input  wire logic reg_outval,
    input  wire logic reg_din_en,
    input  wire logic pullup_ovr_en,
    input  wire logic pullup_ovr_val,
    input  wire logic dir_ovr_en,
    input  wire logic dir_ovr_val,
    input  wire logic outval_ovr_en,
    input  wire logic outval_ovr_val,
    input  wire logic din_en_ovr_en,
    input  wire logic din_en_ovr_val,
    output logic      pull_en,
    output logic      dir,
    output logic      outval,
    output logic      din_en
);
    logic next_pullup;
    logic next_dir;
    logic next_outval;
    logic next_din_en;

    always_comb
    begin
        next_pullup = pullup_ovr_en ? pullup_ovr_val : reg_pullup;
        next_dir    = dir_ovr_en    ? dir_ovr_val    : reg_dir;
        next_outval = outval_ovr_en ? outval_ovr_val : reg_outval;
        next_din_en = din_en_ovr_en ? din_en_ovr_val : reg_din_en;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pull_en <= 1'b0;
            dir     <= 1'b0;
            outval  <= 1'b0;
            din_en  <= 1'b0;
        end
        else
        begin
            pull_en <= next_pullup;
            dir     <= next_dir;
            outval  <= next_outval;
            din_en  <= next_din_en;
        end
    end
endmodule
`default_nettype wire

/* File: pbm_top.sv */
// Port B alternate function mux with APB configuration registers.
//
// Summary of operation
// - Pin 0 is oscillator pin one except with the RC oscillator.
// - Pin 1 is oscillator pin two only for crystal clock sources.
// - Compare-A output reaches pin 2 only with its direction bit set.
// - Pin 2 carries the PWM waveform in PWM modes too.
// - Clock-output fuse drives system clock on pin 2, but not in reset, where the pin flops hold 0.
// - Pin 2 input forced on by external irq or pin-change source.
// - Pin 3 is the active-low reset when reset-disable fuse unprogrammed.
// - Reset-disable flag or debug overrides pin 3, pull-up value one.
// - Debug is active only with its fuse programmed and locks clear.
// - Debug makes pin 3 open-drain, driven low only while transmitting.
// - Pins 0..3 feed pin-change group one sources 8..11.
// - Crystal clocks override pins 0,1; external clock overrides pin 0.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pbm_top
    import pbm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sysclk_level,
    input  wire logic        tmr0_cmp_a_out,
    input  wire logic        tmr0_cmp_a_en,
    input  wire logic        debug_transmit,
    input  wire logic        power_down_state,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_pullup,
    output logic      [3:0]  pin_dir,
    output logic      [3:0]  pin_outval,
    output logic      [3:0]  pin_din_en,
    output logic             onewire_debug_active,
    output logic             ext_reset_n,
    output logic      [3:0]  pinchg_src
);
    import pbm_pkg::*;

    // ==========================================================
    // Register state
    logic [31:0] ctrl;
    logic [31:0] fuse;
    logic [31:0] src;
    logic [31:0] next_ctrl;
    logic [31:0] next_fuse;
    logic [31:0] next_src;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [3:0]  ovr_vec;

    wire logic acc     = psel && !penable;
    wire logic wr_done = psel && penable && pready && pwrite;

    always_comb
    begin
        next_ctrl    = ctrl;
        next_fuse    = fuse;
        next_src     = src;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (acc)
        begin
            next_pready = 1'b1;
            if (pwrite)
            begin
                case (paddr)
                    PBM_CTRL_OFS: next_pslverr = 1'b0;
                    PBM_FUSE_OFS: next_pslverr = 1'b0;
                    PBM_SRC_OFS:  next_pslverr = 1'b0;
                    PBM_STAT_OFS: next_pslverr = 1'b0;
                    PBM_OVR_OFS:  next_pslverr = 1'b0;
                    default:      next_pslverr = 1'b1;
                endcase
            end
            else
            begin
                case (paddr)
                    PBM_CTRL_OFS: next_prdata = ctrl;
                    PBM_FUSE_OFS: next_prdata = fuse;
                    PBM_SRC_OFS:  next_prdata = src;
                    PBM_STAT_OFS: next_prdata = {22'h0, onewire_debug_active, ext_reset_n,
                                                 pin_din_en, pin_in};
                    PBM_OVR_OFS:  next_prdata = {12'h0, pin_outval, pin_dir, pin_pullup, ovr_vec, 4'h0};
                    default:
                    begin
                        next_prdata  = 32'h0000_0000;
                        next_pslverr = 1'b1;
                    end
                endcase
            end
        end
        // Writes land at the edge that completes the access phase, where the master sees pready.
        if (wr_done)
        begin
            case (paddr)
                PBM_CTRL_OFS: next_ctrl = {18'h0, pwdata[13:0]};
                PBM_FUSE_OFS: next_fuse = {26'h0, pwdata[5:0]};
                PBM_SRC_OFS:  next_src  = {30'h0, pwdata[1:0]};
                default:      next_ctrl = ctrl;
            endcase
        end
    end

    // Answer lands one cycle after setup, so the access phase is always one cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl    <= PBM_CTRL_RST;
            fuse    <= PBM_FUSE_RST;
            src     <= PBM_SRC_RST;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl    <= next_ctrl;
            fuse    <= next_fuse;
            src     <= next_src;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Decoded conditions
    wire logic [3:0] port_bits = ctrl[PBM_CTRL_PORT_LSB +: 4];
    wire logic [3:0] dir_bits  = ctrl[PBM_CTRL_DIR_LSB +: 4];
    wire logic [3:0] src_mask  = ctrl[PBM_CTRL_MASK_LSB +: 4];
    wire logic pinchg_group1_en = ctrl[PBM_CTRL_GRP_BIT];
    wire logic ext_irq_zero     = ctrl[PBM_CTRL_EXT_IRQ_ZERO_BIT];
    wire logic sysclk_out_fuse   = !fuse[PBM_FUSE_SYSCLK_OUT_FUSE_BIT];
    wire logic reset_pin_disable = !fuse[PBM_FUSE_RSTD_BIT];
    wire logic onewire_debug_fuse = !fuse[PBM_FUSE_ONEWIRE_DEBUG_FUSE_BIT];
    wire logic locks_clear = &fuse[PBM_FUSE_LOCK_LSB +: PBM_LOCK_W];
    wire logic dbg_on = onewire_debug_fuse && locks_clear;
    wire logic crystal_clk_selected = (src[1:0] == PBM_CLK_XTAL) || (src[1:0] == PBM_CLK_LFXTAL);
    wire logic extclk_selected      = (src[1:0] == PBM_CLK_EXT);
    wire logic [3:0] src_en = src_mask & {4{pinchg_group1_en}};

    // Register-derived defaults; pull-up when input with port bit high.
    logic [3:0] ovr_pu_en, ovr_pu_val, ovr_dd_en, ovr_dd_val;
    logic [3:0] ovr_pv_en, ovr_pv_val, ovr_di_en, ovr_di_val;

    always_comb
    begin
        // Pin 0: oscillator pin one unless the RC oscillator runs.
        ovr_pu_en[0]  = extclk_selected || crystal_clk_selected;
        ovr_pu_val[0] = 1'b0;
        ovr_dd_en[0]  = ovr_pu_en[0];
        ovr_dd_val[0] = 1'b0;
        ovr_pv_en[0]  = ovr_pu_en[0];
        ovr_pv_val[0] = 1'b0;
        ovr_di_en[0]  = ovr_pu_en[0] || src_en[0];
        ovr_di_val[0] = (extclk_selected && !power_down_state)
                      || (!extclk_selected && !crystal_clk_selected && src_en[0]);
        // Pin 1: oscillator pin two for crystal sources only.
        ovr_pu_en[1]  = crystal_clk_selected;
        ovr_pu_val[1] = 1'b0;
        ovr_dd_en[1]  = crystal_clk_selected;
        ovr_dd_val[1] = 1'b0;
        ovr_pv_en[1]  = crystal_clk_selected;
        ovr_pv_val[1] = 1'b0;
        ovr_di_en[1]  = crystal_clk_selected || src_en[1];
        ovr_di_val[1] = src_en[1];
        // Pin 2: clock output wins over the compare output.
        ovr_pu_en[2]  = sysclk_out_fuse;
        ovr_pu_val[2] = 1'b0;
        ovr_dd_en[2]  = sysclk_out_fuse;
        ovr_dd_val[2] = 1'b1;
        // Compare enable covers PWM too; direction stays under software control.
        ovr_pv_en[2]  = sysclk_out_fuse || (tmr0_cmp_a_en && dir_bits[2]);
        ovr_pv_val[2] = sysclk_out_fuse ? sysclk_level : tmr0_cmp_a_out;
        ovr_di_en[2]  = src_en[2] || ext_irq_zero;
        ovr_di_val[2] = src_en[2] || ext_irq_zero;
        // Pin 3: reset input, or open-drain debug line.
        ovr_pu_en[3]  = reset_pin_disable || dbg_on;
        ovr_pu_val[3] = 1'b1;
        ovr_dd_en[3]  = reset_pin_disable || dbg_on;
        ovr_dd_val[3] = dbg_on && debug_transmit;
        ovr_pv_en[3]  = reset_pin_disable || dbg_on;
        ovr_pv_val[3] = 1'b0;
        ovr_di_en[3]  = reset_pin_disable || dbg_on || src_en[3];
        ovr_di_val[3] = dbg_on || (reset_pin_disable && src_en[3]);
        // Reset pin use: pull-up on, driver and input off.
        if (!reset_pin_disable && !dbg_on)
        begin
            ovr_pu_en[3]  = 1'b1;
            ovr_dd_en[3]  = 1'b1;
            ovr_dd_val[3] = 1'b0;
            ovr_di_en[3]  = 1'b1;
            ovr_di_val[3] = 1'b0;
        end
    end

    assign ovr_vec = ovr_pu_en | ovr_dd_en | ovr_pv_en | ovr_di_en;

    // ==========================================================
    // Per-pin combiners
    genvar g;
    generate
        for (g = 0; g < PBM_NPIN; g++)
        begin : g_pin
            pbm_pin_mux u_pin
            (
                .pclk           (pclk),
                .presetn        (presetn),
                .reg_pullup     (port_bits[g] && !dir_bits[g]),
                .reg_dir        (dir_bits[g]),
                .reg_outval     (port_bits[g]),
                .reg_din_en     (1'b1),
                .pullup_ovr_en  (ovr_pu_en[g]),
                .pullup_ovr_val (ovr_pu_val[g]),
                .dir_ovr_en     (ovr_dd_en[g]),
                .dir_ovr_val    (ovr_dd_val[g]),
                .outval_ovr_en  (ovr_pv_en[g]),
                .outval_ovr_val (ovr_pv_val[g]),
                .din_en_ovr_en  (ovr_di_en[g]),
                .din_en_ovr_val (ovr_di_val[g]),
                .pull_en        (pin_pullup[g]),
                .dir            (pin_dir[g]),
                .outval         (pin_outval[g]),
                .din_en         (pin_din_en[g])
            );
        end
    endgenerate

    // Side outputs, registered; the reset line idles high when not in reset use.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            onewire_debug_active <= 1'b0;
            ext_reset_n          <= 1'b1;
            pinchg_src           <= 4'h0;
        end
        else
        begin
            onewire_debug_active <= dbg_on;
            ext_reset_n          <= (reset_pin_disable || dbg_on) ? 1'b1 : pin_in[3];
            pinchg_src           <= pin_in & src_en;
        end
    end

    // ==========================================================
    // Checks
    apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("pready did not follow setup");
    sysclk_out_fuse_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(sysclk_out_fuse) |-> (pin_dir[2] && !pin_pullup[2]))
        else $error("clock output pin not forced");
    cmp_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(!sysclk_out_fuse && !dir_bits[2])) |-> !pin_dir[2])
        else $error("pin 2 drives without direction bit");
    ext_irq_zero_din_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ext_irq_zero) |-> pin_din_en[2])
        else $error("pin 2 input not enabled");
    // The pin flops still hold their reset values at the first edge after release.
    rst_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(presetn) && $past(!reset_pin_disable && !dbg_on)) |-> (pin_pullup[3] && !pin_dir[3] && !pin_din_en[3]))
        else $error("reset pin setup wrong");
    dbg_od_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(dbg_on) |-> (!pin_outval[3] && pin_pullup[3] && (pin_dir[3] == $past(debug_transmit))))
        else $error("debug line not open-drain");
    dbg_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        onewire_debug_active |-> $past(onewire_debug_fuse && locks_clear))
        else $error("debug active without fuse");
    osc_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(crystal_clk_selected) |-> (pin_dir[1:0] == 2'h0 && pin_pullup[1:0] == 2'h0))
        else $error("oscillator pins not overridden");
endmodule
`default_nettype wire

/* File: pbm_pins.sv */
// Behavioural model of the pins, the clock source, the reset source and the emulator.
`timescale 1ns/1ps
`default_nettype none
module pbm_pins
(
    input  wire logic       pclk,
    input  wire logic [3:0] pin_pullup,
    input  wire logic [3:0] pin_dir,
    input  wire logic [3:0] pin_outval,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] ext_val,
    input  wire logic       emu_low,
    output logic      [3:0] pin_in
);
    logic flt = 1'b0;

    // A pin nobody drives and nothing pulls floats; a toggling level keeps it from posing as a stable one.
    always @(posedge pclk)
        flt <= ~flt;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
            pin_in[i] = pin_dir[i] ? pin_outval[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] ? 1'b1 : flt;
        // Pin three is wired-AND: any party may pull it low, otherwise the pull-up lifts it.
        pin_in[3] = ((pin_dir[3] & ~pin_outval[3]) | emu_low | (ext_en[3] & ~ext_val[3])) ? 1'b0 :
                    (pin_pullup[3] | ext_en[3]) ? 1'b1 : flt;
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench of the port B alternate function mux.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    import pbm_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, onewire_debug_active, ext_reset_n, emu_low = 1'b0;
    logic        sysclk_level = 1'b0, tmr0_cmp_a_out = 1'b0, tmr0_cmp_a_en = 1'b0;
    logic        debug_transmit = 1'b0, power_down_state = 1'b0;
    logic [3:0]  pin_in, pin_pullup, pin_dir, pin_outval, pin_din_en, pinchg_src;
    logic [3:0]  ext_en = 4'hF, ext_val = 4'h8;
    int          num_errors = 0, checks_done = 0, cycles = 0;
    logic [1:0]  ov_t [4] = '{2'h3, 2'h2, 2'h0, 2'h0};
    logic [1:0]  di_t [4] = '{2'h3, 2'h3, 2'h0, 2'h0};
    logic [31:0] fz_t [3] = '{32'h23, 32'h13, 32'h37};

    pbm_top u_pbm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sysclk_level(sysclk_level), .tmr0_cmp_a_out(tmr0_cmp_a_out), .tmr0_cmp_a_en(tmr0_cmp_a_en),
        .debug_transmit(debug_transmit), .power_down_state(power_down_state), .pin_in(pin_in),
        .pin_pullup(pin_pullup), .pin_dir(pin_dir), .pin_outval(pin_outval), .pin_din_en(pin_din_en),
        .onewire_debug_active(onewire_debug_active), .ext_reset_n(ext_reset_n), .pinchg_src(pinchg_src));

    pbm_pins u_pbm_pins (.pclk(pclk), .pin_pullup(pin_pullup), .pin_dir(pin_dir), .pin_outval(pin_outval),
        .ext_en(ext_en), .ext_val(ext_val), .emu_low(emu_low), .pin_in(pin_in));

    initial
    begin
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // Closing, timeout and bus tasks
    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // The slave's answer is waited for, never assumed; release happens at the pready edge, or after 50 cycles without pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        `CHK(pready, 1'b1)
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic pins(input logic [3:0] pu, input logic [3:0] dr, input logic [3:0] ov, input logic [3:0] di);
        `CHK(pin_pullup, pu)
        `CHK(pin_dir, dr)
        `CHK(pin_outval, ov)
        `CHK(pin_din_en, di)
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        pins(4'h8, 4'h0, 4'h0, 4'h7);
        `CHK(ext_reset_n, 1'b1)
        rdc(PBM_FUSE_OFS, PBM_FUSE_RST);
        rdc(PBM_SRC_OFS, PBM_SRC_RST);
        rdc(8'h14, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, PBM_STAT_OFS, 32'hFFFF_FFFF);
        `CHK(err, 1'b0)
        rdc(PBM_STAT_OFS, 32'h0000_0178);
        apb(1'b1, PBM_CTRL_OFS, 32'h0000_0045);
        settle();
        pins(4'h9, 4'h4, 4'h5, 4'h7);
        rdc(PBM_CTRL_OFS, 32'h0000_0045);
        tmr0_cmp_a_en <= 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            @(posedge pclk);
            tmr0_cmp_a_out <= v[0];
            settle();
            `CHK(pin_outval[2], v[0])
        end
        @(posedge pclk);
        tmr0_cmp_a_en <= 1'b0;
        apb(1'b1, PBM_CTRL_OFS, 32'h0000_0033);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, PBM_SRC_OFS, 32'(s));
            settle();
            `CHK(pin_dir[1:0], ov_t[s])
            `CHK(pin_outval[1:0], ov_t[s])
            `CHK(pin_din_en[1:0], di_t[s])
        end
        apb(1'b1, PBM_SRC_OFS, 32'h1);
        power_down_state <= 1'b1;
        settle();
        `CHK(pin_din_en[0], 1'b0)
        apb(1'b1, PBM_SRC_OFS, 32'h0);
        power_down_state <= 1'b0;
        apb(1'b1, PBM_CTRL_OFS, 32'h0000_0004);
        apb(1'b1, PBM_FUSE_OFS, 32'h0000_0036);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge pclk);
            sysclk_level <= v[0];
            settle();
            `CHK(pin_outval[2], v[0])
            `CHK(pin_dir[2], 1'b1)
            `CHK(pin_pullup[2], 1'b0)
        end
        apb(1'b1, PBM_FUSE_OFS, 32'h0000_0033);
        rdc(PBM_FUSE_OFS, 32'h0000_0033);
        debug_transmit <= 1'b1;
        settle();
        `CHK(onewire_debug_active, 1'b1)
        pins(4'hC, 4'h8, 4'h4, 4'hF);
        `CHK(pin_in[3], 1'b0)
        @(posedge pclk);
        debug_transmit <= 1'b0;
        settle();
        `CHK(pin_dir[3], 1'b0)
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, PBM_FUSE_OFS, fz_t[i]);
            settle();
            `CHK(onewire_debug_active, 1'b0)
        end
        @(posedge pclk);
        ext_val <= 4'h0;
        settle();
        `CHK(ext_reset_n, 1'b0)
        apb(1'b1, PBM_CTRL_OFS, 32'h0000_1F00);
        ext_val <= 4'hA;
        settle();
        `CHK(ext_reset_n, 1'b1)
        `CHK(pinchg_src, 4'hA)
        `CHK(pin_din_en, 4'h7)
        apb(1'b1, PBM_CTRL_OFS, 32'h0000_1600);
        settle();
        `CHK(pinchg_src, 4'h2)
        apb(1'b1, PBM_CTRL_OFS, 32'h0000_0F00);
        settle();
        `CHK(pinchg_src, 4'h0)
        end_sim();
    end
endmodule
`default_nettype wire
